// >>> design/asfw_top.v
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "asfw_consts.vh"

// ****************************************
// Two-stage synchroniser
// ****************************************
module asfw_sync2 #(
  parameter W = 1
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);

  reg [W-1:0] meta;

  // The first stage feeds only the second stage.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule // asfw_sync2

// ****************************************
// Auxiliary status words
// ****************************************
module asfw_top (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [`ASFW_ADDR_W-1:0] i_addr,
  input wire [`ASFW_DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [`ASFW_DATA_W-1:0] o_rdata,
  input wire [`ASFW_RANGE_N-1:0] i_range_match,
  input wire i_pulse_active,
  input wire i_cassette_present,
  input wire i_cassette_clock,
  input wire i_cassette_wprot,
  input wire [`ASFW_CAS_CODE_W-1:0] i_cassette_code,
  output reg o_irq
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  wire [`ASFW_RANGE_N-1:0] range_sync;
  wire pulse_sync;
  wire present_sync;
  wire clock_sync;
  wire wprot_sync;
  wire [`ASFW_CAS_CODE_W-1:0] code_sync;

  asfw_sync2 #(
    .W(`ASFW_RANGE_N)
  ) u_sync_range (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async(i_range_match),
    .o_sync(range_sync)
  );

  asfw_sync2 #(
    .W(1)
  ) u_sync_pulse (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async(i_pulse_active),
    .o_sync(pulse_sync)
  );

  asfw_sync2 #(
    .W(3)
  ) u_sync_cas_flags (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async({i_cassette_present, i_cassette_clock, i_cassette_wprot}),
    .o_sync({present_sync, clock_sync, wprot_sync})
  );

  asfw_sync2 #(
    .W(`ASFW_CAS_CODE_W)
  ) u_sync_cas_code (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async(i_cassette_code),
    .o_sync(code_sync)
  );

  // ****************************************
  // Counter range and pulse flags
  // ****************************************
  reg [`ASFW_RANGE_N-1:0] range_flags;
  reg pulse_flag;

  // Flags follow the synchronised sources on every edge, so any change shows.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      range_flags <= {`ASFW_RANGE_N{1'b0}};
      pulse_flag <= 1'b0;
    end else begin
      range_flags <= range_sync;
      pulse_flag <= pulse_sync;
    end
  end

  // ****************************************
  // Power-up cassette sampling
  // ****************************************
  reg [`ASFW_SAMPLE_CNT_W-1:0] sample_cnt;
  reg sample_done;
  reg present_flag;

  // Presence is caught once, after the synchroniser has filled with real pin
  // values, and then held until the next reset.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sample_cnt <= {`ASFW_SAMPLE_CNT_W{1'b0}};
      sample_done <= 1'b0;
      present_flag <= 1'b0;
    end else if (!sample_done) begin
      if (sample_cnt == `ASFW_SAMPLE_DELAY) begin
        sample_done <= 1'b1;
        present_flag <= present_sync;
      end else begin
        sample_cnt <= sample_cnt + {{(`ASFW_SAMPLE_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************
  // Cassette clock, protection and type
  // ****************************************
  reg clock_flag;
  reg wprot_flag;
  reg [`ASFW_CAS_CODE_W-1:0] code_field;
  reg next_wprot;
  reg [`ASFW_CAS_CODE_W-1:0] next_code;

  // Unknown codes read as no cassette; protection follows the cassette kind.
  always @* begin
    next_wprot = 1'b0;
    next_code = `ASFW_CODE_NONE;
    case (code_sync)
      `ASFW_CODE_EEPROM_4K, `ASFW_CODE_EEPROM_8K, `ASFW_CODE_FLASH_16K: begin
        next_code = code_sync;
        next_wprot = wprot_sync;
      end
      `ASFW_CODE_EPROM: begin
        next_code = code_sync;
        next_wprot = 1'b1;
      end
      default: begin
        next_code = `ASFW_CODE_NONE;
        next_wprot = 1'b0;
      end
    endcase
  end

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clock_flag <= 1'b0;
      wprot_flag <= 1'b0;
      code_field <= `ASFW_CODE_NONE;
    end else begin
      clock_flag <= clock_sync;
      wprot_flag <= next_wprot;
      code_field <= next_code;
    end
  end

  // ****************************************
  // Assembled status words
  // ****************************************
  reg [`ASFW_DATA_W-1:0] counter_word;
  reg [`ASFW_DATA_W-1:0] cassette_word;

  always @* begin
    counter_word = `ASFW_ZERO_WORD;
    counter_word[`ASFW_RANGE_MSB:`ASFW_RANGE_LSB] = range_flags;
    counter_word[`ASFW_PULSE_BIT] = pulse_flag;
    cassette_word = `ASFW_ZERO_WORD;
    cassette_word[`ASFW_CAS_PRESENT_BIT] = present_flag;
    cassette_word[`ASFW_CAS_CLOCK_BIT] = clock_flag;
    cassette_word[`ASFW_CAS_WPROT_BIT] = wprot_flag;
    cassette_word[`ASFW_CAS_CODE_MSB:`ASFW_CAS_CODE_LSB] = code_field;
  end

  // ****************************************
  // Event detection and interrupt
  // ****************************************
  reg [`ASFW_RANGE_N-1:0] range_prev;
  reg pulse_prev;
  reg [`ASFW_IRQ_W-1:0] irq_status;
  reg [`ASFW_IRQ_W-1:0] irq_enable;
  reg [`ASFW_IRQ_W-1:0] events;
  reg [`ASFW_IRQ_W-1:0] clear_mask;
  reg [`ASFW_IRQ_W-1:0] next_status;
  reg [`ASFW_IRQ_W-1:0] next_enable;

  // Range entry and pulse start/stop are the events.
  // A source already high when reset lifts counts as an entry, since its flag restarts low.
  always @* begin
    events = `ASFW_IRQ_ZERO;
    events[`ASFW_RANGE_MSB:`ASFW_RANGE_LSB] = range_flags & ~range_prev;
    events[`ASFW_IRQ_PULSE_START_BIT] = pulse_flag & ~pulse_prev;
    events[`ASFW_IRQ_PULSE_STOP_BIT] = ~pulse_flag & pulse_prev;
  end

  always @* begin
    clear_mask = `ASFW_IRQ_ZERO;
    next_enable = irq_enable;
    if (i_wr && (i_addr == `ASFW_OFS_IRQ_CLEAR)) begin
      clear_mask = i_wdata[`ASFW_IRQ_W-1:0];
    end
    if (i_wr && (i_addr == `ASFW_OFS_IRQ_ENABLE)) begin
      next_enable = i_wdata[`ASFW_IRQ_W-1:0];
    end
    // A new event in the clearing cycle survives the clear.
    next_status = (irq_status & ~clear_mask) | events;
  end

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      range_prev <= {`ASFW_RANGE_N{1'b0}};
      pulse_prev <= 1'b0;
      irq_status <= `ASFW_IRQ_ZERO;
      irq_enable <= `ASFW_IRQ_ZERO;
    end else begin
      range_prev <= range_flags;
      pulse_prev <= pulse_flag;
      irq_status <= next_status;
      irq_enable <= next_enable;
    end
  end

  // The line is built from the next values, so it rises on the edge that sets
  // the status bit and drops on the edge that clears or disables it.
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(next_status & next_enable);
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  reg [`ASFW_DATA_W-1:0] next_rdata;

  // Writes to the status words have no target and are dropped.
  always @* begin
    next_rdata = `ASFW_ZERO_WORD;
    if (i_rd) begin
      case (i_addr)
        `ASFW_OFS_IRQ_STATUS: begin
          next_rdata[`ASFW_IRQ_W-1:0] = irq_status;
        end
        `ASFW_OFS_IRQ_ENABLE: begin
          next_rdata[`ASFW_IRQ_W-1:0] = irq_enable;
        end
        // The clear register is write-only and reads as zero.
        `ASFW_OFS_IRQ_CLEAR: begin
          next_rdata = `ASFW_ZERO_WORD;
        end
        `ASFW_OFS_COUNTER_RANGE_PULSE_STATUS: begin
          next_rdata = counter_word;
        end
        `ASFW_OFS_UNUSED_AUX_WORD: begin
          next_rdata = `ASFW_ZERO_WORD;
        end
        `ASFW_OFS_CASSETTE_STATUS: begin
          next_rdata = cassette_word;
        end
        default: begin
          next_rdata = `ASFW_ZERO_WORD;
        end
      endcase
    end
  end

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= `ASFW_ZERO_WORD;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule // asfw_top

`default_nettype wire

// >>> design/asfw_consts.vh
// How it works
// - Counter word bits 0-7 follow eight independent range-match inputs of counter 0.
// - Counter word bit 15 reads 1 while pulse output runs, 0 when stopped.
// - Cassette word bit 0 holds cassette presence sampled once after each reset.
// - Cassette word bit 1 is set when the fitted cassette has a clock.
// - Cassette word bit 2 set for protected EEPROM/flash, always for EPROM.
// - Cassette word bits 4-7 hold type code 0 none to 4 EPROM.
// - Word 0xC, counter bits 8-14 and cassette bit 3 read as zero.
`ifndef ASFW_CONSTS_VH
`define ASFW_CONSTS_VH

// ****************************************
// Bus geometry
// ****************************************
`define ASFW_ADDR_W 4
`define ASFW_DATA_W 16
`define ASFW_ZERO_WORD 16'h0000

// ****************************************
// Register offsets
// ****************************************
`define ASFW_OFS_IRQ_STATUS 4'h0
`define ASFW_OFS_IRQ_CLEAR 4'h1
`define ASFW_OFS_IRQ_ENABLE 4'h2
`define ASFW_OFS_COUNTER_RANGE_PULSE_STATUS 4'hB
`define ASFW_OFS_UNUSED_AUX_WORD 4'hC
`define ASFW_OFS_CASSETTE_STATUS 4'hD

// ****************************************
// Counter word fields
// ****************************************
`define ASFW_RANGE_N 8
`define ASFW_RANGE_LSB 0
`define ASFW_RANGE_MSB 7
`define ASFW_PULSE_BIT 15

// ****************************************
// Cassette word fields
// ****************************************
`define ASFW_CAS_PRESENT_BIT 0
`define ASFW_CAS_CLOCK_BIT 1
`define ASFW_CAS_WPROT_BIT 2
`define ASFW_CAS_CODE_LSB 4
`define ASFW_CAS_CODE_MSB 7
`define ASFW_CAS_CODE_W 4

// ****************************************
// Cassette type codes
// ****************************************
`define ASFW_CODE_NONE 4'h0
`define ASFW_CODE_EEPROM_4K 4'h1
`define ASFW_CODE_EEPROM_8K 4'h2
`define ASFW_CODE_FLASH_16K 4'h3
`define ASFW_CODE_EPROM 4'h4

// ****************************************
// Interrupt status fields
// ****************************************
`define ASFW_IRQ_W 10
`define ASFW_IRQ_PULSE_START_BIT 8
`define ASFW_IRQ_PULSE_STOP_BIT 9
`define ASFW_IRQ_ZERO 10'h000

// ****************************************
// Power-up sampling
// ****************************************
`define ASFW_SAMPLE_CNT_W 2
`define ASFW_SAMPLE_DELAY 2'h3

`endif

// >>> bench/asfw_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Status word checks
// ****************************************
module asfw_chk (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [7:0] i_range_match,
  input wire logic i_pulse_active,
  input wire logic i_cassette_clock,
  input wire logic [3:0] i_cassette_code
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  sequence rd_cnt;
    i_rd && i_addr == 4'hB;
  endsequence
  sequence rd_cas;
    i_rd && i_addr == 4'hD;
  endsequence
  range_flags_a:
    assert property (rd_cnt |=> o_rdata[7:0] == $past(i_range_match, 4)) else $error("range flags wrong");
  pulse_flag_a:
    assert property (rd_cnt |=> o_rdata[15] == $past(i_pulse_active, 4)) else $error("pulse flag wrong");
  cnt_unused_a:
    assert property (rd_cnt |=> o_rdata[14:8] == 7'h00) else $error("counter spare bits set");
  aux_unused_a:
    assert property (i_rd && i_addr == 4'hC |=> o_rdata == 16'h0000) else $error("unused word not zero");
  cas_unused_a:
    assert property (rd_cas |=> o_rdata[3] == 1'b0 && o_rdata[15:8] == 8'h00) else $error("cassette spare set");
  cas_clock_a:
    assert property (rd_cas |=> o_rdata[1] == $past(i_cassette_clock, 4)) else $error("clock flag wrong");
  cas_code_a:
    assert property (rd_cas |=> o_rdata[7:4] == ($past(i_cassette_code, 4) > 4'h4 ? 4'h0 : $past(i_cassette_code, 4)))
      else $error("cassette code wrong");
  eprom_wprot_a:
    assert property (rd_cas ##1 $past(i_cassette_code, 4) == 4'h4 |-> o_rdata[2]) else $error("wprot not forced");
  read_idle_a:
    assert property (!i_rd |=> o_rdata == 16'h0000) else $error("read data without read");
endmodule // asfw_chk

bind asfw_top asfw_chk u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_range_match(i_range_match), .i_pulse_active(i_pulse_active),
  .i_cassette_clock(i_cassette_clock), .i_cassette_code(i_cassette_code));
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rm = 8'h00;
  logic pa = 1'b0;
  logic cp = 1'b1;
  logic cc = 1'b0;
  logic cw = 1'b0;
  logic [3:0] code = 4'h0;
  wire [15:0] rdata;
  wire irq;
  int error_cnt = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  asfw_top u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_range_match(rm), .i_pulse_active(pa), .i_cassette_present(cp),
    .i_cassette_clock(cc), .i_cassette_wprot(cw), .i_cassette_code(code), .o_irq(irq));
  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic stop_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_counter;
    logic [7:0] m;
    for (int n = 0; n < 8; n++) begin
      m = 8'h01 << n;
      @(posedge clk);
      rm <= m;
      pa <= n[0];
      repeat (5) @(posedge clk);
      rd_reg(4'hB, {n[0], 7'h00, m});
    end
  endtask
  task automatic t_aux;
    wr_reg(4'hB, 16'hFFFF);
    wr_reg(4'hC, 16'hFFFF);
    wr_reg(4'hD, 16'hFFFF);
    rd_reg(4'hB, 16'h8080);
    rd_reg(4'hC, 16'h0000);
    rd_reg(4'h5, 16'h0000);
  endtask
  task automatic t_cassette;
    logic [3:0] c;
    for (int n = 0; n < 7; n++) begin
      c = n[3:0];
      @(posedge clk);
      cp <= 1'b0;
      code <= (n == 6) ? 4'h1 : c;
      cc <= c[0];
      cw <= (n == 6);
      repeat (5) @(posedge clk);
      if (n == 6) begin
        rd_reg(4'hD, 16'h0015);
      end else begin
        rd_reg(4'hD, {8'h00, (c > 4'h4) ? 4'h0 : c, 1'b0, c == 4'h4, c[0], 1'b1});
      end
    end
  endtask
  task automatic t_irq;
    @(posedge clk);
    rm <= 8'h00;
    repeat (5) @(posedge clk);
    wr_reg(4'h1, 16'h03FF);
    wr_reg(4'h2, 16'h0001);
    rd_reg(4'h0, 16'h0000);
    @(posedge clk);
    rm <= 8'h01;
    for (int i = 0; i < 10 && irq !== 1'b1; i++) begin
      @(posedge clk);
    end
    if (irq !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t interrupt never rose", $time);
      stop_test();
    end
    rd_reg(4'h0, 16'h0001);
    wr_reg(4'h2, 16'h0000);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(4'h2, 16'h0001);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(4'h1, 16'h0001);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    rd_reg(4'h0, 16'h0000);
    rd_reg(4'h2, 16'h0001);
  endtask
  task automatic t_reset;
    @(posedge clk);
    nrst <= 1'b0;
    cp <= 1'b0;
    code <= 4'h2;
    cc <= 1'b1;
    cw <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk(rdata, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(rdata, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    repeat (8) @(posedge clk);
    cp <= 1'b1;
    repeat (5) @(posedge clk);
    rd_reg(4'hD, 16'h0026);
    rd_reg(4'h0, 16'h0101);
    @(posedge clk);
    pa <= 1'b0;
    repeat (5) @(posedge clk);
    rd_reg(4'h0, 16'h0301);
    wr_reg(4'h2, 16'h0200);
    #1;
    chk({15'h0000, irq}, 16'h0001);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    rd_reg(4'h0, 16'h0000);
    rd_reg(4'h2, 16'h0000);
    t_counter();
    t_aux();
    t_cassette();
    t_irq();
    t_reset();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
